// ==== common/cfg_regs_consts.vh ====
`ifndef CFG_REGS_CONSTS_VH
`define CFG_REGS_CONSTS_VH

`define OFS_BOOT_ROM_SIZE_CONFIG   8'h51
`define OFS_LED_WAKE_POWER_CONFIG  8'h52

`define EE_MODE_CFG_WRITE          2'h3

`define BIT_PM_ENABLE              0
`define BIT_PD_ENABLE              1
`define BIT_IO_MAPPED              2
`define BIT_MEM_MAPPED             3
`define BIT_WAKE_POLARITY          4
`define BIT_DRIVER_LOADED          5
`define LSB_LED_SCHEME             6
`define MSB_LED_SCHEME             7
`define LSB_BOOT_ROM_SIZE          0
`define MSB_BOOT_ROM_SIZE          2

`define RST_BOOT_ROM_SIZE          3'h0
`define RST_LED_SCHEME             2'h0
`define RST_DRIVER_LOADED          1'h0
`define RST_WAKE_POLARITY          1'h0
`define RST_MEM_MAPPED             1'h1
`define RST_IO_MAPPED              1'h1
`define RST_PD_ENABLE              1'h0
`define RST_PM_ENABLE              1'h0

`define PM_CAP_POINTER             8'hdc
`define PM_CAP_ID                  8'h01

`define CLK_PERIOD_NS              40
`define WAKE_PULSE_MS              150
`define WAKE_PULSE_CYCLES          ((`WAKE_PULSE_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ==== core/wake_pin_driver.v ====
`timescale 1ns/1ps
`include "cfg_regs_consts.vh"

module wake_pin_driver #(
    parameter PULSE_CYCLES = `WAKE_PULSE_CYCLES,
    parameter CNT_W        = 22
) (
    input  wire clk,
    input  wire reset_n,
    input  wire wake_request,
    input  wire wake_polarity_sel,
    input  wire wake_pulse_sel,
    output reg  wake_output_pin
);
    localparam [CNT_W-1:0] PULSE_LOAD = PULSE_CYCLES[CNT_W-1:0];

    reg             request_seen;
    reg [CNT_W-1:0] pulse_count;
    reg             asserted;

    // Pulse style restarts on each new wake request edge
    always @(posedge clk) begin
        if (!reset_n) begin
            request_seen <= 1'b0;
            pulse_count  <= {CNT_W{1'b0}};
        end else begin
            request_seen <= wake_request;
            if (wake_request && !request_seen)
                pulse_count <= PULSE_LOAD;
            else if (pulse_count != {CNT_W{1'b0}})
                pulse_count <= pulse_count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        if (wake_pulse_sel)
            asserted = (pulse_count != {CNT_W{1'b0}});
        else
            asserted = wake_request;
    end

    always @(posedge clk) begin
        if (!reset_n)
            wake_output_pin <= 1'b0;
        else
            wake_output_pin <= asserted ^ wake_polarity_sel;
    end
endmodule

// ==== core/boot_led_wake_pm_config_regs.v ====
`timescale 1ns/1ps
`include "cfg_regs_consts.vh"

module boot_led_wake_pm_config_regs #(
    parameter WAKE_PULSE_CYCLES = `WAKE_PULSE_CYCLES,
    parameter WAKE_CNT_W        = 22,
    parameter VPD_CAP_POINTER   = 8'h00
) (
    input  wire       CLK,
    input  wire       RESET_N,
    input  wire [7:0] REG_ADDR,
    input  wire       REG_WR,
    input  wire       REG_RD,
    input  wire [7:0] REG_WDATA,
    output reg  [7:0] REG_RDATA,
    input  wire [1:0] EEPROM_OP_MODE,
    input  wire       EE_LOAD,
    input  wire [7:0] EE_BOOT_ROM_SIZE_CONFIG,
    input  wire [7:0] EE_LED_WAKE_POWER_CONFIG,
    input  wire       PCI_CMD_WRITE,
    input  wire       WAKE_REQUEST,
    input  wire       WAKE_PULSE_SEL,
    output wire       WAKE_OUTPUT_PIN,
    output reg  [1:0] LED_SCHEME_SEL,
    output reg        DRIVER_LOADED_FLAG,
    output reg        PRODUCT_DATA_ENABLE,
    output reg        MEMORY_SPACE_MAPPED,
    output reg        IO_SPACE_MAPPED,
    output reg        NEW_CAP_STATUS,
    output reg  [7:0] CAP_POINTER,
    output reg  [7:0] PM_CAP_ID,
    output reg  [7:0] PM_NEXT_POINTER,
    output reg        PM_REGS_VALID
);
    reg  [2:0] boot_rom_size_sel;
    reg        wake_polarity_sel;
    reg        power_mgmt_enable;
    reg  [7:0] next_rdata;
    wire       cfg_write_open;
    wire       wr_config1;
    wire       rd_config0;
    wire       rd_config1;

    function hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hit = (addr == offset);
        end
    endfunction

    assign cfg_write_open = (EEPROM_OP_MODE == `EE_MODE_CFG_WRITE);
    assign wr_config1 = REG_WR && cfg_write_open
                        && hit(REG_ADDR, `OFS_LED_WAKE_POWER_CONFIG);
    assign rd_config0 = hit(REG_ADDR, `OFS_BOOT_ROM_SIZE_CONFIG);
    assign rd_config1 = hit(REG_ADDR, `OFS_LED_WAKE_POWER_CONFIG);

    // Boot ROM size and mapping bits change only on EEPROM load
    always @(posedge CLK) begin
        if (!RESET_N) begin
            boot_rom_size_sel   <= `RST_BOOT_ROM_SIZE;
            MEMORY_SPACE_MAPPED <= `RST_MEM_MAPPED;
            IO_SPACE_MAPPED     <= `RST_IO_MAPPED;
        end else if (EE_LOAD) begin
            boot_rom_size_sel   <=
                EE_BOOT_ROM_SIZE_CONFIG[`MSB_BOOT_ROM_SIZE:`LSB_BOOT_ROM_SIZE];
            MEMORY_SPACE_MAPPED <= EE_LED_WAKE_POWER_CONFIG[`BIT_MEM_MAPPED];
            IO_SPACE_MAPPED     <= EE_LED_WAKE_POWER_CONFIG[`BIT_IO_MAPPED];
        end
    end

    // Writable fields: EEPROM load first, then software writes
    always @(posedge CLK) begin
        if (!RESET_N) begin
            LED_SCHEME_SEL      <= `RST_LED_SCHEME;
            wake_polarity_sel   <= `RST_WAKE_POLARITY;
            PRODUCT_DATA_ENABLE <= `RST_PD_ENABLE;
            power_mgmt_enable   <= `RST_PM_ENABLE;
        end else if (EE_LOAD) begin
            LED_SCHEME_SEL      <=
                EE_LED_WAKE_POWER_CONFIG[`MSB_LED_SCHEME:`LSB_LED_SCHEME];
            wake_polarity_sel   <= EE_LED_WAKE_POWER_CONFIG[`BIT_WAKE_POLARITY];
            PRODUCT_DATA_ENABLE <= EE_LED_WAKE_POWER_CONFIG[`BIT_PD_ENABLE];
            power_mgmt_enable   <= EE_LED_WAKE_POWER_CONFIG[`BIT_PM_ENABLE];
        end else if (wr_config1) begin
            LED_SCHEME_SEL      <= REG_WDATA[`MSB_LED_SCHEME:`LSB_LED_SCHEME];
            wake_polarity_sel   <= REG_WDATA[`BIT_WAKE_POLARITY];
            PRODUCT_DATA_ENABLE <= REG_WDATA[`BIT_PD_ENABLE];
            power_mgmt_enable   <= REG_WDATA[`BIT_PM_ENABLE];
        end
    end

    // Software write wins over the command-register clear in the same cycle
    always @(posedge CLK) begin
        if (!RESET_N)
            DRIVER_LOADED_FLAG <= `RST_DRIVER_LOADED;
        else if (wr_config1)
            DRIVER_LOADED_FLAG <= REG_WDATA[`BIT_DRIVER_LOADED];
        else if (PCI_CMD_WRITE || EE_LOAD)
            DRIVER_LOADED_FLAG <= 1'b0;
    end

    always @* begin
        next_rdata = 8'h00;
        if (rd_config0) begin
            next_rdata[`MSB_BOOT_ROM_SIZE:`LSB_BOOT_ROM_SIZE] = boot_rom_size_sel;
        end else if (rd_config1) begin
            next_rdata[`MSB_LED_SCHEME:`LSB_LED_SCHEME] = LED_SCHEME_SEL;
            next_rdata[`BIT_DRIVER_LOADED] = DRIVER_LOADED_FLAG;
            next_rdata[`BIT_WAKE_POLARITY] = wake_polarity_sel;
            next_rdata[`BIT_MEM_MAPPED]    = MEMORY_SPACE_MAPPED;
            next_rdata[`BIT_IO_MAPPED]     = IO_SPACE_MAPPED;
            next_rdata[`BIT_PD_ENABLE]     = PRODUCT_DATA_ENABLE;
            next_rdata[`BIT_PM_ENABLE]     = power_mgmt_enable;
        end
    end

    // Read data held until the next read
    always @(posedge CLK) begin
        if (!RESET_N)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            REG_RDATA <= next_rdata;
    end

    // Capability chain hidden while power management is off
    always @(posedge CLK) begin
        if (!RESET_N) begin
            NEW_CAP_STATUS  <= 1'b0;
            CAP_POINTER     <= 8'h00;
            PM_CAP_ID       <= 8'h00;
            PM_NEXT_POINTER <= 8'h00;
            PM_REGS_VALID   <= 1'b0;
        end else if (power_mgmt_enable) begin
            NEW_CAP_STATUS  <= 1'b1;
            CAP_POINTER     <= `PM_CAP_POINTER;
            PM_CAP_ID       <= `PM_CAP_ID;
            PM_NEXT_POINTER <= PRODUCT_DATA_ENABLE ? VPD_CAP_POINTER : 8'h00;
            PM_REGS_VALID   <= 1'b1;
        end else begin
            NEW_CAP_STATUS  <= 1'b0;
            CAP_POINTER     <= 8'h00;
            PM_CAP_ID       <= 8'h00;
            PM_NEXT_POINTER <= 8'h00;
            PM_REGS_VALID   <= 1'b0;
        end
    end

    wake_pin_driver #(
        .PULSE_CYCLES (WAKE_PULSE_CYCLES),
        .CNT_W        (WAKE_CNT_W)
    ) wake_driver (
        .clk               (CLK),
        .reset_n           (RESET_N),
        .wake_request      (WAKE_REQUEST),
        .wake_polarity_sel (wake_polarity_sel),
        .wake_pulse_sel    (WAKE_PULSE_SEL),
        .wake_output_pin   (WAKE_OUTPUT_PIN)
    );
endmodule

// ==== testbench/cfg_regs_properties.sv ====
`timescale 1ns/1ps
`include "cfg_regs_consts.vh"
module cfg_regs_checker (
    input wire       CLK,
    input wire       RESET_N,
    input wire [7:0] REG_ADDR,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire [1:0] EEPROM_OP_MODE,
    input wire       EE_LOAD,
    input wire       PCI_CMD_WRITE,
    input wire [1:0] LED_SCHEME_SEL,
    input wire       DRIVER_LOADED_FLAG,
    input wire       PRODUCT_DATA_ENABLE,
    input wire       MEMORY_SPACE_MAPPED,
    input wire       IO_SPACE_MAPPED,
    input wire [7:0] CAP_POINTER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    reg  [15:0] wd;
    wire        wr_ok = REG_WR && REG_ADDR == 8'h52 && EEPROM_OP_MODE == 2'h3 && !EE_LOAD;
    // Write data one and two cycles back
    always @(posedge CLK) wd <= {wd[7:0], REG_WDATA};
    property p_ro; REG_RD && REG_ADDR == 8'h51 |=> REG_RDATA[7:3] == 5'h00; endproperty
    a_ro: assert property (p_ro) else $error("boot size upper bits set");
    property p_map; !EE_LOAD |=> $stable(MEMORY_SPACE_MAPPED); endproperty
    a_map: assert property (p_map) else $error("mapped bit changed");
    property p_io_space_mapped; !EE_LOAD |=> $stable(IO_SPACE_MAPPED); endproperty
    a_io_space_mapped: assert property (p_io_space_mapped) else $error("io mapped bit changed");
    property p_clr; PCI_CMD_WRITE && !REG_WR && !EE_LOAD |=> !DRIVER_LOADED_FLAG; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_flag; wr_ok |=> DRIVER_LOADED_FLAG == wd[5]; endproperty
    a_flag: assert property (p_flag) else $error("flag not stored");
    property p_led; wr_ok |=> LED_SCHEME_SEL == wd[7:6]; endproperty
    a_led: assert property (p_led) else $error("led select not stored");
    property p_vpd; wr_ok |=> PRODUCT_DATA_ENABLE == wd[1]; endproperty
    a_vpd: assert property (p_vpd) else $error("vpd enable not stored");
    property p_lock; REG_WR && EEPROM_OP_MODE != 2'h3 && !EE_LOAD
        |=> $stable(LED_SCHEME_SEL) && $stable(PRODUCT_DATA_ENABLE); endproperty
    a_lock: assert property (p_lock) else $error("locked write took effect");
    property p_pm; wr_ok |=> ##1 CAP_POINTER == (wd[8] ? `PM_CAP_POINTER : 8'h00); endproperty
    a_pm: assert property (p_pm) else $error("capability pointer wrong");
endmodule
bind boot_led_wake_pm_config_regs cfg_regs_checker cfg_regs_checker_inst (.CLK(CLK),
    .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EEPROM_OP_MODE(EEPROM_OP_MODE),
    .EE_LOAD(EE_LOAD), .PCI_CMD_WRITE(PCI_CMD_WRITE), .LED_SCHEME_SEL(LED_SCHEME_SEL),
    .DRIVER_LOADED_FLAG(DRIVER_LOADED_FLAG), .PRODUCT_DATA_ENABLE(PRODUCT_DATA_ENABLE),
    .MEMORY_SPACE_MAPPED(MEMORY_SPACE_MAPPED), .IO_SPACE_MAPPED(IO_SPACE_MAPPED),
    .CAP_POINTER(CAP_POINTER));

// ==== testbench/eeprom_image_model.sv ====
`timescale 1ns/1ps
module eeprom_image_model #(
    parameter BOOT_IMG = 8'hfd,
    parameter LED_IMG  = 8'hb3
) (
    input  wire       clk,
    input  wire       reset_n,
    output reg        ee_load,
    output wire [7:0] boot_img,
    output wire [7:0] led_img
);
    reg loaded;
    // Image is only valid with the load strobe
    assign boot_img = ee_load ? BOOT_IMG : ~BOOT_IMG;
    assign led_img  = ee_load ? LED_IMG : ~LED_IMG;
    always @(posedge clk) begin
        loaded  <= reset_n;
        ee_load <= reset_n && !loaded;
    end
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    reg        clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, cmd_wr = 1'b0;
    reg        wake_req = 1'b0, pulse_sel = 1'b0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00;
    reg  [1:0] mode = 2'h3;
    wire [7:0] rdata, boot_img, led_img, cap_ptr, cap_id, next_ptr;
    wire       ee_load, wake_pin, io_map, new_cap, regs_valid;
    integer    n_errors = 0, comparisons = 0, i;
    always #20 clk = ~clk;
    eeprom_image_model eeprom_image_model_inst (.clk(clk), .reset_n(reset_n),
        .ee_load(ee_load), .boot_img(boot_img), .led_img(led_img));
    boot_led_wake_pm_config_regs #(.WAKE_PULSE_CYCLES(8), .WAKE_CNT_W(4),
        .VPD_CAP_POINTER(8'h60))
    boot_led_wake_pm_config_regs_inst (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .EEPROM_OP_MODE(mode), .EE_LOAD(ee_load), .EE_BOOT_ROM_SIZE_CONFIG(boot_img),
        .EE_LED_WAKE_POWER_CONFIG(led_img), .PCI_CMD_WRITE(cmd_wr), .WAKE_REQUEST(wake_req),
        .WAKE_PULSE_SEL(pulse_sel), .WAKE_OUTPUT_PIN(wake_pin), .LED_SCHEME_SEL(),
        .DRIVER_LOADED_FLAG(), .PRODUCT_DATA_ENABLE(), .MEMORY_SPACE_MAPPED(),
        .IO_SPACE_MAPPED(io_map), .NEW_CAP_STATUS(new_cap), .CAP_POINTER(cap_ptr),
        .PM_CAP_ID(cap_id), .PM_NEXT_POINTER(next_ptr), .PM_REGS_VALID(regs_valid));
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
            end
        end
    endtask
    task wr_reg(input [1:0] m, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            mode <= m;
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: timeout", $time);
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'h51, 8'h05);
        rd_chk(8'h52, 8'h93);
        chk(cap_ptr, 8'hdc);
        chk(next_ptr, 8'h60);
        chk({6'h00, new_cap, regs_valid}, 8'h03);
        chk({7'h00, io_map}, 8'h00);
        wr_reg(2'h3, 8'h51, 8'hfa);
        rd_chk(8'h51, 8'h05);
        for (i = 0; i < 3; i = i + 1) begin
            wr_reg(i[1:0], 8'h52, 8'h6e);
            rd_chk(8'h52, 8'h93);
        end
        $display("test load and lock done");
        wr_reg(2'h3, 8'h52, 8'h6e);
        rd_chk(8'h52, 8'h62);
        chk(cap_ptr, 8'h00);
        chk(cap_id, 8'h00);
        chk(next_ptr, 8'h00);
        chk({6'h00, new_cap, regs_valid}, 8'h00);
        @(posedge clk);
        cmd_wr <= 1'b1;
        @(posedge clk);
        cmd_wr <= 1'b0;
        rd_chk(8'h52, 8'h42);
        wr_reg(2'h3, 8'h52, 8'h21);
        rd_chk(8'h52, 8'h21);
        chk(cap_ptr, 8'hdc);
        chk(cap_id, 8'h01);
        chk(next_ptr, 8'h00);
        chk({6'h00, new_cap, regs_valid}, 8'h03);
        $display("test write and pm done");
        @(posedge clk);
        wake_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h01);
        wr_reg(2'h3, 8'h52, 8'h31);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h00);
        @(posedge clk);
        pulse_sel <= 1'b1;
        wake_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h01);
        @(posedge clk);
        wake_req <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h00);
        repeat (5) @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h01);
        wr_reg(2'h3, 8'h52, 8'h21);
        wake_req <= 1'b0;
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, wake_pin}, 8'h01);
        $display("test wake done");
        tally_and_finish;
    end
endmodule
